// >>> pkg/cstm_pkg.sv
// constants shared by the chip-select timing machine
package cstm_pkg;
   // ------------------------------------------------------------------
   // structure
   // ------------------------------------------------------------------
   localparam int NUM_BANKS    = 4;
   localparam int BANK_IDX_W   = 2;
   localparam int LANES        = 4;
   localparam int WAIT_W       = 4;
   localparam int CNT_W        = 5;
   localparam int ACS_W        = 2;
   localparam int PW_W         = 2;
   localparam int BEAT_W       = 2;
   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 25;
   localparam int HOLD_GAP_CLKS  = 1;
   localparam int BASIC_CLKS     = 2;
   localparam int MAX_WAIT       = 15;
   localparam int RELAX_MIN_WAIT = 1;
   // ------------------------------------------------------------------
   // codes and values
   // ------------------------------------------------------------------
   localparam logic [ACS_W-1:0]      ACS_SAME    = 2'h0;
   localparam logic [ACS_W-1:0]      ACS_QUARTER = 2'h2;
   localparam logic [ACS_W-1:0]      ACS_HALF    = 2'h3;
   localparam logic [BEAT_W-1:0]     BEAT_LAST   = 2'h3;
   localparam logic [BEAT_W-1:0]     BEAT_STEP   = 2'h1;
   localparam logic [CNT_W-1:0]      CNT_ZERO    = 5'h00;
   localparam logic [CNT_W-1:0]      CNT_ONE     = 5'h01;
   localparam logic [NUM_BANKS-1:0]  BOOT_BANK   = 4'h1;
   localparam logic [NUM_BANKS-1:0]  NO_BANKS    = 4'h0;
   localparam logic [LANES-1:0]      NO_LANES    = 4'h0;
   localparam logic [BANK_IDX_W-1:0] BANK0       = 2'h0;
   // ------------------------------------------------------------------
   // state machine
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_GAP    = 4'b0010,
      ST_SETUP  = 4'b0100,
      ST_ACCESS = 4'b1000
   } cstm_state_e;
endpackage : cstm_pkg

// >>> rtl/cstm_chip_select_timing_machine.sv
// chip-select timing machine for external memory banks
//
// Overview of operation
// - bursts only on reads; writes always single transfers
// - burst allowed only while the bank's burst_block is clear
// - at most four beats, stop at modulo-four word boundary
// - unmatched burst goes external; outside logic terminates each beat
// - normal or late sampling of burst_data_in_progress
// - matched bank supplies every cycle attribute
// - per-lane byte strobes for reads and writes, plus read strobe
// - boot chip select active straight out of reset
// - relaxed timing adds strobe delay and doubles wait states
// - after read with hold extend, next cycle waits one clock unless it reads the same bank
// - select delay and early negate set strobe setup and hold
// - select delay 00 asserts select with the address
// - select delay 11 asserts select half a clock later
// - early negate without relaxed drops write strobe quarter clock early
// - zero to 15 wait states then internal acknowledge
// - basic cycle lasts two clocks plus wait count
// - external ack with relaxed needs one wait, three clocks least
// - early external ack ends internally timed cycle
// - write data driven right after transfer start
// - lowest numbered matching bank wins
// - write to protected bank: no select, no ack, flag set
`timescale 1ns/1ps
module cstm_chip_select_timing_machine
   import cstm_pkg::*;
(
   input  wire logic                                   clk_sys_in,
   input  wire logic                                   nrst_in,
   input  wire logic                                   transfer_start_in,
   input  wire logic                                   read_in,
   input  wire logic                                   burst_req_in,
   input  wire logic [cstm_pkg::LANES-1:0]             byte_enable_in,
   input  wire logic [cstm_pkg::BEAT_W-1:0]            word_addr_in,
   input  wire logic [cstm_pkg::NUM_BANKS-1:0]         access_match_in,
   input  wire logic [cstm_pkg::NUM_BANKS-1:0]         bank_valid_in,
   input  wire logic [cstm_pkg::NUM_BANKS-1:0]         burst_block_in,
   input  wire logic [cstm_pkg::NUM_BANKS-1:0]         write_protect_in,
   input  wire logic [cstm_pkg::NUM_BANKS-1:0]         relaxed_timing_in,
   input  wire logic [cstm_pkg::NUM_BANKS-1:0]         read_hold_extend_in,
   input  wire logic [cstm_pkg::NUM_BANKS-1:0]         external_ack_select_in,
   input  wire logic [cstm_pkg::NUM_BANKS-1:0]         strobe_early_negate_in,
   input  wire logic [cstm_pkg::NUM_BANKS*2-1:0]       address_to_select_delay_in,
   input  wire logic [cstm_pkg::NUM_BANKS*4-1:0]       wait_count_in,
   input  wire logic [cstm_pkg::NUM_BANKS*4-1:0]       burst_wait_count_in,
   input  wire logic [cstm_pkg::NUM_BANKS*2-1:0]       port_width_in,
   input  wire logic                                   burst_data_in_progress_late_in,
   input  wire logic                                   boot_release_in,
   input  wire logic [cstm_pkg::NUM_BANKS-1:0]         violation_clear_in,
   input  wire logic                                   transfer_ack_n_in,
   input  wire logic                                   burst_data_in_progress_n_in,
   output logic [cstm_pkg::NUM_BANKS-1:0]              bank_chip_select_out,
   output logic [cstm_pkg::LANES-1:0]                  byte_write_strobe_out,
   output logic                                        read_strobe_out,
   output logic                                        data_drive_out,
   output logic                                        internal_ack_out,
   output logic                                        external_pass_out,
   output logic                                        burst_active_out,
   output logic [cstm_pkg::ACS_W-1:0]                  select_delay_out,
   output logic                                        strobe_early_negate_out,
   output logic [cstm_pkg::PW_W-1:0]                   port_width_out,
   output logic [cstm_pkg::NUM_BANKS-1:0]              protect_violation_flag_out,
   output logic                                        boot_active_out,
   output logic                                        busy_out
);
   import cstm_pkg::*;

   initial
   begin
      if (NUM_BANKS != 4 || WAIT_W != 4 || CNT_W < WAIT_W + 1)
         $error("unsupported bank count or counter width");
   end

   // ------------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------------
   function automatic logic [BANK_IDX_W-1:0] lowest_bank
      (input logic [NUM_BANKS-1:0] hits);
      logic [BANK_IDX_W-1:0] idx;
      idx = BANK0;
      for (int i = NUM_BANKS - 1; i >= 0; i--)
         if (hits[i])
            idx = BANK_IDX_W'(i);
      return idx;
   endfunction : lowest_bank

   function automatic logic [CNT_W-1:0] beat_load
      (input logic [WAIT_W-1:0] w, input logic relax);
      logic [CNT_W-1:0] ext;
      ext = {1'b0, w};
      return relax ? CNT_W'(ext + ext + CNT_ONE) : CNT_W'(ext + CNT_ONE);
   endfunction : beat_load

   // ------------------------------------------------------------------
   // pin synchronisers (three stages, second and third must agree)
   // ------------------------------------------------------------------
   logic [2:0] ta_sync_ff;
   logic [2:0] burst_data_in_progress_sync_ff;
   logic       ta_filt_ff;
   logic       burst_data_in_progress_filt_ff;
   logic       burst_data_in_progress_late_ff;

   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         ta_sync_ff   <= 3'h7;
         burst_data_in_progress_sync_ff <= 3'h7;
         ta_filt_ff   <= 1'b0;
         burst_data_in_progress_filt_ff <= 1'b0;
         burst_data_in_progress_late_ff <= 1'b0;
      end
      else
      begin
         ta_sync_ff   <= {ta_sync_ff[1:0], transfer_ack_n_in};
         burst_data_in_progress_sync_ff <= {burst_data_in_progress_sync_ff[1:0], burst_data_in_progress_n_in};
         if (ta_sync_ff[1] == ta_sync_ff[2])
            ta_filt_ff <= !ta_sync_ff[2];
         if (burst_data_in_progress_sync_ff[1] == burst_data_in_progress_sync_ff[2])
            burst_data_in_progress_filt_ff <= !burst_data_in_progress_sync_ff[2];
         burst_data_in_progress_late_ff <= burst_data_in_progress_filt_ff;
      end
   end

   wire logic burst_data_in_progress_seen = burst_data_in_progress_late_in ? burst_data_in_progress_late_ff : burst_data_in_progress_filt_ff;

   // ------------------------------------------------------------------
   // state and request registers
   // ------------------------------------------------------------------
   cstm_state_e            st_ff;
   cstm_state_e            nxt_st;
   logic [CNT_W-1:0]       cnt_ff;
   logic [CNT_W-1:0]       nxt_cnt;
   logic [BANK_IDX_W-1:0]  bank_ff;
   logic                   rd_ff;
   logic                   burst_ff;
   logic [BEAT_W-1:0]      beat_ff;
   logic [BEAT_W-1:0]      nxt_beat;
   logic [LANES-1:0]       be_ff;
   logic                   last_rd_ff;
   logic [BANK_IDX_W-1:0]  last_bank_ff;
   logic                   last_read_hold_extend_ff;
   logic                   boot_ff;
   logic [NUM_BANKS-1:0]   viol_ff;

   // ------------------------------------------------------------------
   // bank decode and attribute selection
   // ------------------------------------------------------------------
   wire logic [NUM_BANKS-1:0] valid_w = bank_valid_in | (boot_ff ? BOOT_BANK : NO_BANKS);
   wire logic [NUM_BANKS-1:0] hits_w  = access_match_in & valid_w;
   wire logic                 any_hit = |hits_w;
   wire logic [BANK_IDX_W-1:0] new_bank = lowest_bank(hits_w);
   wire logic                 new_wp  = !read_in && write_protect_in[new_bank];
   wire logic                 start_idle = (st_ff == ST_IDLE) && transfer_start_in;
   wire logic                 accept  = start_idle && any_hit && !new_wp;
   wire logic                 violate = start_idle && any_hit && new_wp;
   wire logic                 pass_w  = start_idle && (!any_hit || new_wp);
   wire logic                 new_burst = read_in && burst_req_in && !burst_block_in[new_bank];
   wire logic                 need_gap = last_read_hold_extend_ff &&
                                 !(read_in && last_rd_ff && last_bank_ff == new_bank);
   wire logic [BANK_IDX_W-1:0] sel_bank = (st_ff == ST_IDLE) ? new_bank : bank_ff;

   // every attribute follows the selected bank
   wire logic               relax_w = relaxed_timing_in[sel_bank];
   wire logic               external_ack_select_w  = external_ack_select_in[sel_bank];
   wire logic               strobe_early_negate_w  = strobe_early_negate_in[sel_bank];
   wire logic [ACS_W-1:0]   acs_w   = address_to_select_delay_in[sel_bank*ACS_W +: ACS_W];
   wire logic [WAIT_W-1:0]  scy_w   = wait_count_in[sel_bank*WAIT_W +: WAIT_W];
   wire logic [WAIT_W-1:0]  burst_wait_count_w  = burst_wait_count_in[sel_bank*WAIT_W +: WAIT_W];
   wire logic [PW_W-1:0]    pw_w    = port_width_in[sel_bank*PW_W +: PW_W];

   // without external ack, load is wait plus one, doubled wait when relaxed
   wire logic [CNT_W-1:0]   first_load = external_ack_select_w ?
                              (relax_w ? CNT_W'(RELAX_MIN_WAIT) : CNT_ZERO) :
                              beat_load(scy_w, relax_w);
   wire logic [CNT_W-1:0]   next_load  = external_ack_select_w ? CNT_ZERO :
                              beat_load(burst_wait_count_w, relax_w);

   // ------------------------------------------------------------------
   // beat termination
   // ------------------------------------------------------------------
   wire logic cnt_done  = (cnt_ff == CNT_ZERO);
   wire logic beat_end  = (st_ff == ST_ACCESS) &&
                          (external_ack_select_w ? (ta_filt_ff && cnt_done)
                                  : (cnt_done || ta_filt_ff));
   wire logic more_beats = burst_ff && burst_data_in_progress_seen && (beat_ff != BEAT_LAST);
   wire logic go_setup  = relax_w;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb
   begin
      nxt_st   = st_ff;
      nxt_cnt  = cnt_ff;
      nxt_beat = beat_ff;
      case (st_ff)
         ST_IDLE:
         begin
            nxt_beat = word_addr_in;
            if (accept)
            begin
               nxt_cnt = first_load;
               if (need_gap)
                  nxt_st = ST_GAP;
               else if (go_setup)
                  nxt_st = ST_SETUP;
               else
                  nxt_st = ST_ACCESS;
            end
         end
         ST_GAP:
         begin
            nxt_st = go_setup ? ST_SETUP : ST_ACCESS;
         end
         ST_SETUP:
         begin
            nxt_st = ST_ACCESS;
         end
         ST_ACCESS:
         begin
            if (beat_end && more_beats)
            begin
               nxt_beat = BEAT_W'(beat_ff + BEAT_STEP);
               nxt_cnt  = next_load;
            end
            else if (beat_end)
               nxt_st = ST_IDLE;
            else if (!cnt_done)
               nxt_cnt = CNT_W'(cnt_ff - CNT_ONE);
         end
         default:
         begin
            nxt_st = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // registered strobes
   // ------------------------------------------------------------------
   wire logic nxt_rd     = (st_ff == ST_IDLE) ? read_in : rd_ff;
   wire logic nxt_access = (nxt_st == ST_ACCESS);
   wire logic nxt_cs     = nxt_access ||
                           (nxt_st == ST_SETUP && acs_w == ACS_SAME);
   wire logic relax_neg  = relax_w && strobe_early_negate_w && (nxt_cnt == CNT_ZERO) && !external_ack_select_w;
   wire logic nxt_we     = nxt_access && !relax_neg;
   wire logic [LANES-1:0] nxt_be = (st_ff == ST_IDLE) ? byte_enable_in : be_ff;
   wire logic [NUM_BANKS-1:0] nxt_cs_vec =
      nxt_cs ? NUM_BANKS'(BOOT_BANK << sel_bank) : NO_BANKS;

   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         st_ff    <= ST_IDLE;
         cnt_ff   <= CNT_ZERO;
         bank_ff  <= BANK0;
         rd_ff    <= 1'b0;
         burst_ff <= 1'b0;
         beat_ff  <= BEAT_LAST;
         be_ff    <= NO_LANES;
      end
      else
      begin
         st_ff   <= nxt_st;
         cnt_ff  <= nxt_cnt;
         beat_ff <= nxt_beat;
         if (accept)
         begin
            bank_ff  <= new_bank;
            rd_ff    <= read_in;
            burst_ff <= new_burst;
            be_ff    <= byte_enable_in;
         end
      end
   end

   // history for the hold-extend gap
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         last_rd_ff   <= 1'b0;
         last_bank_ff <= BANK0;
         last_read_hold_extend_ff <= 1'b0;
      end
      else if (st_ff == ST_ACCESS && nxt_st == ST_IDLE)
      begin
         last_rd_ff   <= rd_ff;
         last_bank_ff <= bank_ff;
         last_read_hold_extend_ff <= rd_ff && read_hold_extend_in[bank_ff];
      end
      else if (pass_w)
         last_read_hold_extend_ff <= 1'b0;
   end

   // boot select and sticky protect flags
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         boot_ff <= 1'b1;
         viol_ff <= NO_BANKS;
      end
      else
      begin
         if (boot_release_in)
            boot_ff <= 1'b0;
         viol_ff <= (viol_ff & ~violation_clear_in) |
                    (violate ? NUM_BANKS'(BOOT_BANK << new_bank) : NO_BANKS);
      end
   end

   // output flip-flops
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         bank_chip_select_out       <= NO_BANKS;
         byte_write_strobe_out      <= NO_LANES;
         read_strobe_out            <= 1'b0;
         data_drive_out             <= 1'b0;
         internal_ack_out           <= 1'b0;
         external_pass_out          <= 1'b0;
         burst_active_out           <= 1'b0;
         select_delay_out           <= ACS_SAME;
         strobe_early_negate_out    <= 1'b0;
         port_width_out             <= '0;
         protect_violation_flag_out <= NO_BANKS;
         boot_active_out            <= 1'b1;
         busy_out                   <= 1'b0;
      end
      else
      begin
         bank_chip_select_out       <= nxt_cs_vec;
         byte_write_strobe_out      <= nxt_we ? nxt_be : NO_LANES;
         read_strobe_out            <= nxt_access && nxt_rd;
         data_drive_out             <= (nxt_st != ST_IDLE) && !nxt_rd;
         internal_ack_out           <= beat_end && !external_ack_select_w;
         external_pass_out          <= pass_w;
         burst_active_out           <= (nxt_st != ST_IDLE) &&
                                       (st_ff == ST_IDLE ? new_burst : burst_ff);
         select_delay_out           <= acs_w;
         strobe_early_negate_out    <= strobe_early_negate_w && !relax_w && !nxt_rd;
         port_width_out             <= pw_w;
         protect_violation_flag_out <= (viol_ff & ~violation_clear_in) |
                    (violate ? NUM_BANKS'(BOOT_BANK << new_bank) : NO_BANKS);
         boot_active_out            <= boot_ff && !boot_release_in;
         busy_out                   <= (nxt_st != ST_IDLE);
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   chk_burst_read_only: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      burst_active_out |-> read_strobe_out || !data_drive_out)
      else $error("burst seen on a write");

   chk_burst_block_gate: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      accept && burst_block_in[new_bank] |=> !burst_ff)
      else $error("burst started on blocked bank");

   chk_beat_boundary: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      beat_end && beat_ff == BEAT_LAST |=> st_ff == ST_IDLE)
      else $error("burst ran past modulo four boundary");

   chk_nomatch_pass: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      start_idle && !any_hit |=> external_pass_out &&
         bank_chip_select_out == NO_BANKS && !internal_ack_out)
      else $error("unmatched access not passed out");

   chk_basic_length: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      accept && !need_gap && !relax_w && !external_ack_select_w && scy_w == 4'h0 &&
         transfer_ack_n_in && ta_sync_ff == 3'h7 && !ta_filt_ff
      |=> bank_chip_select_out != NO_BANKS ##1
          bank_chip_select_out != NO_BANKS ##1 internal_ack_out)
      else $error("zero wait cycle not two clocks");

   chk_hold_gap: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      accept && need_gap |=> st_ff == ST_GAP ##1
         $past(bank_chip_select_out) == NO_BANKS)
      else $error("hold extend gap missing");

   chk_protect_flag: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      violate |=> protect_violation_flag_out[$past(new_bank)] &&
         bank_chip_select_out == NO_BANKS)
      else $error("protect violation not flagged");

   chk_lowest_bank: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      accept && hits_w[0] |=> bank_ff == BANK0)
      else $error("lower bank not preferred");

   chk_boot_reset: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      $rose(nrst_in) |-> boot_ff && boot_active_out)
      else $error("boot select not active after reset");

   chk_write_data: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      accept && !read_in |=> data_drive_out && !read_strobe_out)
      else $error("write data not driven after start");

endmodule : cstm_chip_select_timing_machine

// >>> tb/cstm_ext_memory.sv
// external device model: acknowledge and burst-in-progress pins
`timescale 1ns/1ps
module cstm_ext_memory
   import cstm_pkg::*;
(
   input  wire logic                          clk_sys_in,
   input  wire logic                          nrst_in,
   input  wire logic [cstm_pkg::NUM_BANKS-1:0] chip_select_in,
   input  wire logic                          ack_en_in,
   input  wire logic [3:0]                    ack_dly_in,
   input  wire logic                          burst_data_in_progress_hold_in,
   output logic                               transfer_ack_n_out,
   output logic                               burst_data_in_progress_n_out
);
   logic       sel_ff;
   logic       run_ff;
   logic       hold_ff;
   logic [3:0] cnt_ff;
   wire logic  start_w = ack_en_in && !sel_ff && (|chip_select_in);
   wire logic  fire_w  = run_ff && (cnt_ff == 4'h0) && !start_w;
   // acknowledge idles high, two-clock low pulse a set delay after select
   // so that the pin filter of the design accepts it
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         sel_ff             <= 1'b0;
         run_ff             <= 1'b0;
         hold_ff            <= 1'b0;
         cnt_ff             <= 4'h0;
         transfer_ack_n_out <= 1'b1;
      end
      else
      begin
         sel_ff             <= |chip_select_in;
         hold_ff            <= fire_w;
         transfer_ack_n_out <= !(fire_w || hold_ff);
         if (start_w)
         begin
            run_ff <= 1'b1;
            cnt_ff <= ack_dly_in;
         end
         else if (fire_w)
            run_ff <= 1'b0;
         else if (run_ff)
            cnt_ff <= cnt_ff - 4'h1;
      end
   end
   assign burst_data_in_progress_n_out = ~burst_data_in_progress_hold_in;
endmodule : cstm_ext_memory

// >>> tb/tb_chip_select_timing_machine.sv
// self-checking bench for the chip-select timing machine
`timescale 1ns/1ps
module tb_chip_select_timing_machine;
   import cstm_pkg::*;
   logic clk_sys_in, nrst_in, transfer_start_in, read_in, burst_req_in;
   logic burst_data_in_progress_late_in, boot_release_in, transfer_ack_n_in, busy_out;
   logic burst_data_in_progress_n_in, read_strobe_out, data_drive_out;
   logic internal_ack_out, external_pass_out, burst_active_out;
   logic strobe_early_negate_out, boot_active_out, ack_en, burst_data_in_progress_hold;
   logic rs_seen, pass_seen, dd_first, sen_seen, ba_seen;
   logic [3:0] byte_enable_in, access_match_in, bank_valid_in;
   logic [3:0] burst_block_in, write_protect_in, relaxed_timing_in;
   logic [3:0] read_hold_extend_in, external_ack_select_in, ack_dly;
   logic [3:0] strobe_early_negate_in, violation_clear_in, pw_sd;
   logic [3:0] bank_chip_select_out, byte_write_strobe_out;
   logic [3:0] protect_violation_flag_out, cs_seen, bws_seen;
   logic [1:0] word_addr_in, select_delay_out, port_width_out;
   logic [7:0] address_to_select_delay_in, port_width_in;
   logic [15:0] wait_count_in, burst_wait_count_in;
   int fail_count, compares, first, acks, cs_cnt;
   cstm_chip_select_timing_machine uut (.clk_sys_in, .nrst_in,
      .transfer_start_in, .read_in, .burst_req_in, .byte_enable_in,
      .word_addr_in, .access_match_in, .bank_valid_in, .burst_block_in,
      .write_protect_in, .relaxed_timing_in, .read_hold_extend_in,
      .external_ack_select_in, .strobe_early_negate_in,
      .address_to_select_delay_in, .wait_count_in, .burst_wait_count_in,
      .port_width_in, .burst_data_in_progress_late_in, .boot_release_in, .violation_clear_in,
      .transfer_ack_n_in, .burst_data_in_progress_n_in,
      .bank_chip_select_out, .byte_write_strobe_out, .read_strobe_out,
      .data_drive_out, .internal_ack_out, .external_pass_out,
      .burst_active_out, .select_delay_out, .strobe_early_negate_out,
      .port_width_out, .protect_violation_flag_out, .boot_active_out,
      .busy_out);
   cstm_ext_memory mem (.clk_sys_in, .nrst_in,
      .chip_select_in(bank_chip_select_out), .ack_en_in(ack_en),
      .ack_dly_in(ack_dly), .burst_data_in_progress_hold_in(burst_data_in_progress_hold),
      .transfer_ack_n_out(transfer_ack_n_in),
      .burst_data_in_progress_n_out(burst_data_in_progress_n_in));
   initial
   begin
      clk_sys_in = 1'b0;
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end
   task tally_and_finish();
      if (fail_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask : chk
   // one access: start pulse, then watch until busy drops
   task acc(input logic rd, input logic bu, input logic [1:0] wa);
      int n;
      {transfer_start_in, read_in, burst_req_in, word_addr_in} = {1'b1,rd,bu,wa};
      @(posedge clk_sys_in);
      #1 transfer_start_in = 1'b0;
      {first, acks, cs_cnt, cs_seen, bws_seen, pw_sd} = '0;
      {rs_seen, pass_seen, dd_first, sen_seen, ba_seen} = 5'h0;
      for (n = 1; n <= 60; n++)
      begin
         if (n == 1) dd_first = data_drive_out;
         cs_seen |= bank_chip_select_out;
         if (bank_chip_select_out !== 4'h0) cs_cnt++;
         bws_seen |= byte_write_strobe_out;
         rs_seen |= read_strobe_out;
         pass_seen |= external_pass_out;
         sen_seen |= strobe_early_negate_out;
         ba_seen |= burst_active_out;
         if (bank_chip_select_out !== 4'h0) pw_sd = {port_width_out, select_delay_out};
         if (internal_ack_out === 1'b1)
         begin
            acks++;
            if (first == 0) first = n;
         end
         if (busy_out !== 1'b1 && n >= 2) break;
         @(posedge clk_sys_in);
         #1;
      end
      if (n > 60)
      begin
         chk(32'h1, 32'h0);
         tally_and_finish();
      end
   endtask : acc
   initial
   begin
      {fail_count, compares, nrst_in, transfer_start_in, read_in} = '0;
      {burst_req_in, word_addr_in, burst_data_in_progress_late_in, boot_release_in} = '0;
      {bank_valid_in, burst_block_in, write_protect_in, ack_en} = '0;
      {relaxed_timing_in, read_hold_extend_in, external_ack_select_in} = '0;
      {strobe_early_negate_in, violation_clear_in, ack_dly, burst_data_in_progress_hold} = '0;
      {wait_count_in, burst_wait_count_in} = '0;
      {byte_enable_in, access_match_in} = {4'hA, 4'h1};
      {address_to_select_delay_in, port_width_in} = {8'h0C, 8'h08};
      repeat (10) @(posedge clk_sys_in);
      #1 nrst_in = 1'b1;
      chk(boot_active_out, 1);
      chk(bank_chip_select_out, 0);
      acc(1, 0, 0); chk(cs_seen, 4'h1); chk(pw_sd, 4'h0);
      boot_release_in = 1'b1;
      @(posedge clk_sys_in);
      #1 {boot_release_in, bank_valid_in, access_match_in} = {1'b0, 8'hF6};
      chk(boot_active_out, 0);
      acc(1, 0, 0); chk(cs_seen, 4'h2);
      chk(bws_seen, 4'hA); chk(rs_seen, 1); chk(first, 3);
      chk(pw_sd, 4'hB);
      wait_count_in = 16'h00F0;
      acc(1, 0, 0); chk(first, 18);
      {ack_en, ack_dly} = 5'h11;
      acc(1, 0, 0); chk(first < 18, 1); chk(acks, 1);
      {wait_count_in, relaxed_timing_in, ack_en} = {16'h0010, 4'h2, 1'b0};
      acc(1, 0, 0); chk(first, 6);
      {external_ack_select_in, ack_dly, ack_en} = 9'h045;
      acc(1, 0, 0); chk(acks, 0); chk(cs_cnt, 9);
      {external_ack_select_in, relaxed_timing_in, ack_en} = 9'h0;
      {wait_count_in, strobe_early_negate_in} = 20'h00002;
      acc(0, 0, 0); chk(dd_first, 1); chk(rs_seen, 0);
      chk(first, 3); chk(sen_seen, 1);
      write_protect_in = 4'h2;
      acc(0, 0, 0); chk({pass_seen, cs_seen, acks[3:0]}, 9'h100);
      chk(protect_violation_flag_out, 4'h2);
      {violation_clear_in, write_protect_in, burst_data_in_progress_hold} = 9'h041;
      repeat (4) @(posedge clk_sys_in);
      #1 violation_clear_in = 4'h0;
      chk(protect_violation_flag_out, 4'h0);
      acc(1, 1, 0); chk(acks, 4); chk(ba_seen, 1);
      acc(1, 1, 2); chk(acks, 2);
      acc(0, 1, 0); chk(acks, 1); chk(ba_seen, 0);
      burst_block_in = 4'h2;
      acc(1, 1, 0); chk(acks, 1);
      {burst_block_in, wait_count_in} = {4'h0, 16'h0020};
      acc(1, 1, 2); chk(first, 5); chk(acks, 2);
      {burst_data_in_progress_hold, wait_count_in} = 17'h0;
      repeat (4) @(posedge clk_sys_in);
      #1 acc(1, 1, 0); chk(acks, 1);
      {burst_data_in_progress_hold, burst_data_in_progress_late_in} = 2'h3;
      repeat (4) @(posedge clk_sys_in);
      #1 burst_data_in_progress_hold = 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1 acc(1, 1, 0); chk(acks, 2);
      {burst_data_in_progress_late_in, access_match_in} = 5'h0;
      acc(1, 1, 0); chk(pass_seen, 1); chk(cs_seen, 0);
      {access_match_in, read_hold_extend_in} = 8'h22;
      acc(1, 0, 0); chk(first, 3);
      acc(1, 0, 0); chk(first, 3); chk(sen_seen, 0);
      acc(0, 0, 0); chk(first, 4);
      tally_and_finish();
   end
endmodule : tb_chip_select_timing_machine
